/* core/smc_pkg.sv */
// Shared constants for the serializer mode and comma control block.
// Assumes a single 50 MHz system clock; byte clock is sampled as data.
package smc_pkg;
    localparam int WORD_W = 10;
    localparam int SER_CNT_W = 4;
    // Seven-bit comma prefix; the first bit to arrive is the top bit.
    localparam logic [6:0] COMMA_PAT = 7'h1F;
    localparam int COMMA_LEN = 7;
    // Serial data rates in MBd, kept for reference only; no module or bench uses them.
    localparam int RATE_HALF_MBD = 1250;
    localparam int RATE_FULL_MBD = 2500;
    localparam logic [WORD_W-1:0] WORD_RST = 10'h000;
    localparam logic SER_IDLE = 1'b1;
endpackage : smc_pkg

/* core/smc_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock domain; no word is lost when the sink stalls.
`timescale 1ns/1ns
module smc_skid #(
    parameter int W = 10
) (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic in_valid, // Word offered.
    output logic in_ready, // Space for a word.
    input wire logic [W-1:0] in_data, // Word in.
    output logic out_valid, // Word available.
    input wire logic out_ready, // Sink takes word.
    output logic [W-1:0] out_data // Oldest word.
);
    logic [W-1:0] mem_q [2];
    logic rd_q;
    logic wr_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) wr_q <= ~wr_q;
            if (pop) rd_q <= ~rd_q;
            if (push && !pop) cnt_q <= cnt_q + 2'd1;
            else if (pop && !push) cnt_q <= cnt_q - 2'd1;
        end
    end
endmodule : smc_skid

/* core/smc_top.sv */
// Mode and comma control for a 10-bit serializer/deserializer.
// Assumes byte clock, data and mode pins are synchronous to SYS_CLK;
// one serial bit is handled per clock cycle in this model.
//
// Notes on behaviour
// (R1) Loopback routes own transmit stream into receiver.
// (R2) Loopback holds output high, ignores input.
// (R3) Comma detection only while enable is high.
// (R4) Flag raised on positive-disparity comma prefix.
// (R5) Rate low: capture on byte-clock falling edge.
// (R6) Rate high: capture on both byte-clock edges.
// (R7) Bit zero transmitted first, least significant.
// (R8) Comma realigns receive word to bit zero.
`timescale 1ns/1ns
module smc_top #(
    parameter int WORD_W = smc_pkg::WORD_W
) (
    input wire logic SYS_CLK, // System clock, 50 MHz.
    input wire logic RESET, // Asynchronous reset, active high.
    input wire logic TRANSMIT_BYTE_CLOCK, // Sampled byte clock.
    input wire logic [WORD_W-1:0] TX_WORD, // Parallel transmit word.
    output logic TX_READY, // Capture path can take a word.
    input wire logic TX_RATE_FULL, // High selects full rate.
    input wire logic SERIAL_LOOPBACK_ENABLE, // Internal loopback.
    input wire logic COMMA_DETECT_ENABLE, // Enables comma search.
    input wire logic SERIAL_IN, // External serial input.
    output logic SERIAL_OUT_PAIR, // External serial output.
    output logic [WORD_W-1:0] RX_WORD, // Received parallel word.
    output logic RX_VALID, // Received word present.
    input wire logic RX_READY, // Receiver takes word.
    output logic COMMA_FOUND_FLAG // Comma seen this word.
);
    // ----------------------------------------------------------------
    // Transmit capture
    // ----------------------------------------------------------------
    logic tbc_q;
    logic cap_fall;
    logic cap_rise;
    logic capture;
    logic buf_valid;
    logic buf_ready;
    logic [WORD_W-1:0] buf_data;

    assign cap_fall = tbc_q && !TRANSMIT_BYTE_CLOCK;
    assign cap_rise = !tbc_q && TRANSMIT_BYTE_CLOCK;
    // Half rate ignores the rising edge entirely.
    assign capture = cap_fall || (TX_RATE_FULL && cap_rise); // R5 R6

    // Reset to the idle low level of the byte clock, so that no false
    // edge is seen in the first cycle after reset.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            tbc_q <= 1'b0;
        end else begin
            tbc_q <= TRANSMIT_BYTE_CLOCK;
        end
    end

    smc_skid #(.W(WORD_W)) u_txbuf (
        .clk(SYS_CLK),
        .rst(RESET),
        .in_valid(capture),
        .in_ready(TX_READY),
        .in_data(TX_WORD),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // ----------------------------------------------------------------
    // Serializer
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] sh_q;
    logic [smc_pkg::SER_CNT_W-1:0] left_q;
    logic ser_bit_q;
    logic ser_act_q;

    // A word is taken only once the last bit of the one before is out.
    assign buf_ready = (left_q == '0);

    // Bit zero leaves first; the line rests at one between words.

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sh_q <= smc_pkg::WORD_RST;
            left_q <= '0;
            ser_bit_q <= smc_pkg::SER_IDLE;
            ser_act_q <= 1'b0;
        end else if (buf_ready && buf_valid) begin
            sh_q <= buf_data >> 1;
            ser_bit_q <= buf_data[0]; // R7
            left_q <= smc_pkg::SER_CNT_W'(WORD_W - 1);
            ser_act_q <= 1'b1;
        end else if (left_q != '0) begin
            ser_bit_q <= sh_q[0]; // R7
            sh_q <= sh_q >> 1;
            left_q <= left_q - 1'b1;
        end else begin
            ser_bit_q <= smc_pkg::SER_IDLE;
            ser_act_q <= 1'b0;
        end
    end

    // Output pair forced to one in loopback so the far end sees idle.
    assign SERIAL_OUT_PAIR = SERIAL_LOOPBACK_ENABLE ? 1'b1 : ser_bit_q; // R2

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    logic rx_bit;
    logic rx_act;
    logic [WORD_W-1:0] rx_sh_q;
    logic [WORD_W-1:0] nxt_sh;

    // Loopback takes the internal stream and disregards SERIAL_IN.
    assign rx_bit = SERIAL_LOOPBACK_ENABLE ? ser_bit_q : SERIAL_IN; // R1 R2
    // In loopback only bits that the serializer really sends are counted,
    // so idle ones between words do not move the word boundary.
    assign rx_act = SERIAL_LOOPBACK_ENABLE ? ser_act_q : 1'b1; // R1
    // Newest bit enters at the top; oldest ends in bit zero.
    assign nxt_sh = {rx_bit, rx_sh_q[WORD_W-1:1]};

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            rx_sh_q <= smc_pkg::WORD_RST;
        end else if (rx_act) begin
            rx_sh_q <= nxt_sh;
        end
    end

    // ----------------------------------------------------------------
    // Comma search
    // ----------------------------------------------------------------
    // The pattern constant keeps its first arrival in the top bit, while
    // the shift register keeps the first arrival in bit zero, so the
    // reference is the pattern reversed, one bit at a time.
    logic [smc_pkg::COMMA_LEN-1:0] comma_ref;
    logic comma_hit;

    for (genvar i = 0; i < smc_pkg::COMMA_LEN; i++) begin : g_comma_ref
        assign comma_ref[i] = smc_pkg::COMMA_PAT[smc_pkg::COMMA_LEN - 1 - i];
    end

    // A hit is taken when the comma's seven fixed bits fill the lowest
    // bits, the moment at which its whole ten-bit character is in view.
    assign comma_hit = COMMA_DETECT_ENABLE && // R3
        (nxt_sh[smc_pkg::COMMA_LEN-1:0] == comma_ref); // R4

    // ----------------------------------------------------------------
    // Word framing
    // ----------------------------------------------------------------
    logic [smc_pkg::SER_CNT_W-1:0] rx_cnt_q;
    logic word_done;
    logic emit;

    assign word_done = rx_cnt_q == smc_pkg::SER_CNT_W'(WORD_W - 1);
    // A comma closes its word at once wherever the old boundary lay, and
    // the count restarts there, so every later word stays aligned to it.
    assign emit = rx_act && (word_done || comma_hit); // R8

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            rx_cnt_q <= '0;
        end else if (emit) begin
            rx_cnt_q <= '0; // R8
        end else if (rx_act) begin
            rx_cnt_q <= rx_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Received word and comma flag
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] rx_word_q;
    logic comma_q;
    logic emit_q;
    logic rx_out_ready;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            rx_word_q <= smc_pkg::WORD_RST;
        end else if (emit) begin
            rx_word_q <= nxt_sh; // R8
        end
    end

    // The flag follows each finished word and drops as soon as
    // detection is switched off, without waiting for the next word.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            comma_q <= 1'b0;
        end else if (emit) begin
            comma_q <= comma_hit; // R4
        end else if (!COMMA_DETECT_ENABLE) begin
            comma_q <= 1'b0; // R3
        end
    end

    // A finished word waits here until the buffer has room. A word
    // finished meanwhile replaces it: a sink that stalls for longer than
    // the buffer can absorb loses words, the price of a short buffer.
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            emit_q <= 1'b0;
        end else if (emit) begin
            emit_q <= 1'b1;
        end else if (rx_out_ready) begin
            emit_q <= 1'b0;
        end
    end

    smc_skid #(.W(WORD_W)) u_rxbuf (
        .clk(SYS_CLK),
        .rst(RESET),
        .in_valid(emit_q),
        .in_ready(rx_out_ready),
        .in_data(rx_word_q),
        .out_valid(RX_VALID),
        .out_ready(RX_READY),
        .out_data(RX_WORD)
    );

    assign COMMA_FOUND_FLAG = comma_q;
endmodule : smc_top

/* tb/smc_mac_model.sv */
// Framing-logic partner: byte clock, transmit word, receive ready.
// Assumes the bench sets the byte-clock half period and the next word.
`timescale 1ns/1ns
module smc_mac_model (
    input wire logic clk, // System clock.
    input wire logic rst, // Reset, active high.
    input wire logic [4:0] gap, // Half period in cycles.
    input wire logic [9:0] word_in, // Next word.
    input wire logic slow, // Stall receive side.
    output logic transmit_byte_clock, // Byte clock.
    output logic [9:0] tx_word, // Parallel word.
    output logic rx_ready // Takes received words.
);
    logic [4:0] cnt = 5'h00;
    initial {transmit_byte_clock, tx_word, rx_ready} = 12'h001;
    // The word moves mid-period so it is steady at either clock edge.
    always @(posedge clk) begin
        #1;
        cnt = (cnt >= gap - 5'h01) ? 5'h00 : cnt + 5'h01;
        if (cnt == 5'h00 && !rst) transmit_byte_clock = !transmit_byte_clock;
        if (cnt == gap / 5'h02) tx_word = word_in;
        rx_ready = !slow || cnt[1];
    end
endmodule : smc_mac_model

/* tb/smc_top_asserts.sv */
// Checker for smc_top: loopback, comma flag, serial timing, rx hold.
// Assumes timed byte-clock edges come at least thirteen cycles apart.
`timescale 1ns/1ns
module smc_top_asserts #(
    parameter int WORD_W = 10
) (
    input wire logic SYS_CLK, // System clock.
    input wire logic RESET, // Reset, active high.
    input wire logic TRANSMIT_BYTE_CLOCK, // Byte clock pin.
    input wire logic [WORD_W-1:0] TX_WORD, // Transmit word.
    input wire logic [WORD_W-1:0] RX_WORD, // Received word.
    input wire logic TX_READY, // Capture space.
    input wire logic TX_RATE_FULL, // Rate select.
    input wire logic SERIAL_IN, // External serial input.
    input wire logic RX_VALID, // Received word present.
    input wire logic SERIAL_LOOPBACK_ENABLE, // Loopback mode.
    input wire logic COMMA_DETECT_ENABLE, // Comma search mode.
    input wire logic SERIAL_OUT_PAIR, // External serial output.
    input wire logic RX_READY, // Sink takes word.
    input wire logic COMMA_FOUND_FLAG // Comma flag.
);
    logic tbc_q;
    logic [4:0] idle_q;
    logic [WORD_W-1:0] word_q;
    wire logic lb = SERIAL_LOOPBACK_ENABLE;
    wire logic so = SERIAL_OUT_PAIR;
    wire logic fl = COMMA_FOUND_FLAG;
    wire logic flip = tbc_q != TRANSMIT_BYTE_CLOCK;
    wire logic cap = TX_READY && flip && (TX_RATE_FULL || tbc_q);
    wire logic go = cap && idle_q > 5'h0B && !lb;
    // Saturating idle count: only a free serializer has a fixed latency.
    always_ff @(posedge SYS_CLK or posedge RESET)
        if (RESET) idle_q <= 5'h1F;
        else if (cap) idle_q <= 5'h00;
        else if (idle_q != 5'h1F) idle_q <= idle_q + 5'h01;
    always_ff @(posedge SYS_CLK or posedge RESET)
        if (RESET) tbc_q <= 1'b0;
        else tbc_q <= TRANSMIT_BYTE_CLOCK;
    always_ff @(posedge SYS_CLK)
        if (cap) word_q <= TX_WORD;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    a_loop_out_high: assert property (lb |-> so)
        else $error("serial output low in loopback");
    a_flag_needs_en: assert property (!COMMA_DETECT_ENABLE [*2] |-> !fl)
        else $error("comma flag with detection off");
    a_flag_rise_en: assert property ($rose(fl) |-> $past(COMMA_DETECT_ENABLE))
        else $error("comma flag rose without enable");
    a_half_fall_cap: assert property (go && !TX_RATE_FULL
        |-> ##2 (lb || so == word_q[0])) else $error("half rate bit 0");
    a_half_rise_skip: assert property (flip && !tbc_q && !TX_RATE_FULL
        && idle_q > 5'h0B |-> ##2 (lb || so)) else $error("rise captured");
    a_full_rise_cap: assert property (go && TX_RATE_FULL && !tbc_q
        |-> ##2 (lb || so == word_q[0])) else $error("full rate bit 0");
    a_bit_order: assert property (go |-> ##3 (lb || so == word_q[1])
        ##7 (lb || so == word_q[8])) else $error("serial bit order");
    a_rx_held: assert property (RX_VALID && !RX_READY
        |=> RX_VALID && $stable(RX_WORD)) else $error("rx word lost");
endmodule : smc_top_asserts
bind smc_top smc_top_asserts #(.WORD_W(WORD_W)) i_smc_top_asserts (
    .SYS_CLK, .RESET, .TRANSMIT_BYTE_CLOCK, .TX_WORD, .RX_WORD, .TX_READY,
    .TX_RATE_FULL, .SERIAL_IN, .RX_VALID, .SERIAL_LOOPBACK_ENABLE,
    .COMMA_DETECT_ENABLE, .SERIAL_OUT_PAIR, .RX_READY, .COMMA_FOUND_FLAG);

/* tb/smc_top_tb.sv */
// Bench for smc_top: transmit timing at both rates, loopback with comma.
// Assumes smc_mac_model drives the parallel side; the checker is bound.
`timescale 1ns/1ns
module smc_top_tb;
    logic clk = 0, rst = 1, rate = 0, lb = 0, en = 0, sin = 0;
    logic slow = 0, seen = 0, prv = 0, transmit_byte_clock, rdy, txr, so, rxv, fl;
    logic [9:0] tw, rw, win = 10'h000;
    logic [4:0] gap = 5'h0E;
    logic [9:0] rxq[$], sent[$];
    int seed = 12, failures = 0, n_checks = 0, cyc = 0, k;
    always #10 clk = !clk;
    smc_top i_smc_top (.SYS_CLK(clk), .RESET(rst), .TX_READY(txr),
        .TRANSMIT_BYTE_CLOCK(transmit_byte_clock), .TX_WORD(tw), .TX_RATE_FULL(rate),
        .SERIAL_LOOPBACK_ENABLE(lb), .COMMA_DETECT_ENABLE(en),
        .SERIAL_IN(sin), .SERIAL_OUT_PAIR(so), .RX_WORD(rw),
        .RX_VALID(rxv), .RX_READY(rdy), .COMMA_FOUND_FLAG(fl));
    smc_mac_model i_smc_mac_model (.clk(clk), .rst(rst), .gap(gap),
        .word_in(win), .slow(slow), .transmit_byte_clock(transmit_byte_clock), .tx_word(tw), .rx_ready(rdy));
    always @(posedge clk) begin
        cyc++;
        prv <= transmit_byte_clock;
        #1 sin <= 1'($random(seed));
        if (cyc > 5000) begin
            failures++;
            final_report();
        end
    end
    // Outputs are looked at mid-cycle, settled to what the next edge uses.
    always @(negedge clk) begin
        seen <= seen | fl;
        if (rxv && rdy) rxq.push_back(rw);
    end
    // Even bits forced high: no two zeros in a row, so no false comma.
    function automatic logic [9:0] rnd_word();
        return 10'($random(seed)) | 10'h155;
    endfunction : rnd_word
    task automatic chk(input logic [9:0] exp, input logic [9:0] act);
        n_checks++;
        if (act !== exp) begin
            failures++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, act);
        end
    endtask : chk
    task automatic edge_wait();
        do @(posedge clk); while (transmit_byte_clock === prv || (!rate && transmit_byte_clock));
    endtask : edge_wait
    task automatic send(input logic [9:0] w);
        edge_wait();
        #1 win = w;
        edge_wait();
    endtask : send
    task automatic tx_test(input logic [9:0] w);
        logic [9:0] got;
        send(w);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #2 got[i] = so;
        end
        chk(w, got);
    endtask : tx_test
    task automatic loop_test(input logic e);
        @(posedge clk);
        #1 en = e;
        lb = 1;
        slow = 1;
        gap = 5'h0A;
        repeat (40) @(posedge clk);
        rxq.delete();
        sent = '{10'h17C, rnd_word(), rnd_word(), rnd_word()};
        #1 seen = 0;
        foreach (sent[j]) send(sent[j]);
        repeat (60) @(posedge clk);
        k = 0;
        while (k < rxq.size() && rxq[k] !== 10'h17C) k++;
        for (int j = 0; j < 8; j++) chk(sent[j / 2], rxq[k + j]);
        chk({9'h000, e}, {9'h000, seen});
        $display("test loopback enable %0d done", e);
    endtask : loop_test
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 0;
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            #1 rate = r[0];
            gap = r[0] ? 5'h14 : 5'h0E;
            tx_test(10'h000);
            tx_test(10'h3FF);
            for (int i = 0; i < 3; i++) tx_test(rnd_word());
            $display("test transmit rate %0d done", r);
        end
        loop_test(1'b1);
        loop_test(1'b0);
        final_report();
    end
endmodule : smc_top_tb
